// [common/ivm_pkg.sv]
// shared constants, source map and types for the interrupt vector mapping block
package ivm_pkg;
    localparam int NUM_IRQ = 192;
    localparam int PRIO_W = 3;
    localparam int IRQ_PER_FLAG_REG = 16;
    localparam int IRQ_PER_PRIO_REG = 4;
    localparam int PRIO_FIELD_STRIDE = 4;
    localparam logic [5:0] FLAG_REGS = 6'h0c;
    localparam logic [5:0] PRIO_REGS = 6'h30;
    localparam logic [7:0] VECTOR_OFFSET = 8'h08;
    localparam logic [23:0] TABLE_BASE = 24'h000004;
    localparam logic [23:0] RESET_ADDR = 24'h000000;
    localparam logic [2:0] CPU_LEVEL_RESET = 3'h0;

    // register map, byte addresses, one word each
    localparam logic [11:0] FLAG_BASE = 12'h000;
    localparam logic [11:0] ENABLE_BASE = 12'h100;
    localparam logic [11:0] PRIO_BASE = 12'h200;
    localparam logic [11:0] CPU_LEVEL_ADDR = 12'h300;
    localparam logic [11:0] STATUS_ADDR = 12'h304;
    localparam logic [11:0] PC_ADDR = 12'h308;

    // source positions by request number; vector is position plus offset
    localparam int IRQ_EXT_REQUEST_ZERO = 0;
    localparam int IRQ_CAPTURE_ONE = 1;
    localparam int IRQ_COMPARE_OUT_ONE = 2;
    localparam int IRQ_TIMER_ONE = 3;
    localparam int IRQ_TIMER_TWO = 7;
    localparam int IRQ_TIMER_THREE = 8;
    localparam int IRQ_SPI_ERROR = 9;
    localparam int IRQ_SPI_DONE_REQUEST = 10;
    localparam int IRQ_SERIAL_RX_REQUEST = 11;
    localparam int IRQ_SERIAL_TX = 12;
    localparam int IRQ_CONVERTER_DONE = 13;
    localparam int IRQ_NONVOLATILE_WRITE_DONE = 15;
    localparam int IRQ_TWO_WIRE_SLAVE = 16;
    localparam int IRQ_TWO_WIRE_MASTER = 17;
    localparam int IRQ_ANALOG_COMPARATOR_ONE = 18;
    localparam int IRQ_INPUT_CHANGE = 19;
    localparam int IRQ_EXT_REQUEST_ONE = 20;
    localparam int IRQ_EXT_REQUEST_TWO = 29;
    localparam int IRQ_MODULATOR_SPECIAL_MATCH = 57;
    localparam int IRQ_SERIAL_ERROR = 65;
    localparam int IRQ_MODULATOR_SECOND_MATCH = 73;
    localparam int IRQ_MODULATOR_GENERATOR_ONE = 94;
    localparam int IRQ_MODULATOR_GENERATOR_TWO = 95;
    localparam int IRQ_MODULATOR_GENERATOR_THREE = 96;
    localparam int IRQ_ANALOG_COMPARATOR_TWO = 103;
    localparam int IRQ_TWO_WIRE_COLLISION = 173;
    localparam int IRQ_CONVERTER_DIGITAL_COMPARE_ZERO = 177;
    localparam int IRQ_CONVERTER_DIGITAL_COMPARE_ONE = 178;
    localparam int IRQ_CONVERTER_OVERSAMPLE_FILTER = 179;

    // reserved positions stay zero here, so they can never be requested
    localparam logic [NUM_IRQ-1:0] IMPL_MASK =
        (192'h1 << IRQ_EXT_REQUEST_ZERO) | (192'h1 << IRQ_CAPTURE_ONE) |
        (192'h1 << IRQ_COMPARE_OUT_ONE) | (192'h1 << IRQ_TIMER_ONE) |
        (192'h1 << IRQ_TIMER_TWO) | (192'h1 << IRQ_TIMER_THREE) |
        (192'h1 << IRQ_SPI_ERROR) | (192'h1 << IRQ_SPI_DONE_REQUEST) |
        (192'h1 << IRQ_SERIAL_RX_REQUEST) | (192'h1 << IRQ_SERIAL_TX) |
        (192'h1 << IRQ_CONVERTER_DONE) | (192'h1 << IRQ_NONVOLATILE_WRITE_DONE) |
        (192'h1 << IRQ_TWO_WIRE_SLAVE) | (192'h1 << IRQ_TWO_WIRE_MASTER) |
        (192'h1 << IRQ_ANALOG_COMPARATOR_ONE) | (192'h1 << IRQ_INPUT_CHANGE) |
        (192'h1 << IRQ_EXT_REQUEST_ONE) | (192'h1 << IRQ_EXT_REQUEST_TWO) |
        (192'h1 << IRQ_MODULATOR_SPECIAL_MATCH) | (192'h1 << IRQ_SERIAL_ERROR) |
        (192'h1 << IRQ_MODULATOR_SECOND_MATCH) | (192'h1 << IRQ_MODULATOR_GENERATOR_ONE) |
        (192'h1 << IRQ_MODULATOR_GENERATOR_TWO) | (192'h1 << IRQ_MODULATOR_GENERATOR_THREE) |
        (192'h1 << IRQ_ANALOG_COMPARATOR_TWO) | (192'h1 << IRQ_TWO_WIRE_COLLISION) |
        (192'h1 << IRQ_CONVERTER_DIGITAL_COMPARE_ZERO) |
        (192'h1 << IRQ_CONVERTER_DIGITAL_COMPARE_ONE) |
        (192'h1 << IRQ_CONVERTER_OVERSAMPLE_FILTER);

    typedef struct packed {
        logic request;
        logic [7:0] number;
        logic [23:0] address;
        logic [2:0] level;
    } ivm_vector_type;

    typedef struct packed {
        logic [NUM_IRQ-1:0] flag;
        logic [NUM_IRQ-1:0] enable;
        logic [NUM_IRQ*PRIO_W-1:0] prio;
        logic [2:0] cpu_level;
        ivm_vector_type vec;
        logic [23:0] program_counter;
        logic boot_fetch;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } ivm_state_type;

    localparam ivm_state_type STATE_RESET = '{
        flag: '0,
        enable: '0,
        prio: '0,
        cpu_level: CPU_LEVEL_RESET,
        vec: '0,
        program_counter: RESET_ADDR,
        boot_fetch: 1'b1,
        pready: 1'b0,
        prdata: 32'h0,
        pslverr: 1'b0
    };
endpackage

// [src/ivm_pick.sv]
// priority picker: highest level wins, lowest position wins a tie
`timescale 1ns/1ps
module ivm_pick #(
    parameter int N = 192,
    parameter int W = 3
) (
    input wire logic [N-1:0] active,
    input wire logic [N*W-1:0] level,
    output logic found,
    output logic [7:0] index,
    output logic [W-1:0] best_level
);
    // scanning downward with >= lets the lower position take equal levels
    always_comb begin
        found = 1'b0;
        index = 8'h00;
        best_level = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (active[i] && (level[i*W +: W] >= best_level)) begin
                found = 1'b1;
                index = 8'(i);
                best_level = level[i*W +: W];
            end
        end
    end
endmodule // ivm_pick

// [src/ivm_controller.sv]
// interrupt vector mapping controller with apb register access
//
// Functional notes
// - reset uses no vector slot
// - reset clears registers, program counter zero
// - first fetch after reset at address zero
// - external request zero: vector 8, bit 0
// - serial receive: vector 19, bit 11
// - converter done: vector 21, bit 13
// - nonvolatile write done: vector 23, bit 15
// - spi done: vector 18, bit 10
// - comparators: vectors 26 and 111
// - modulator special match: vector 65
// - serial error: vector 73
// - modulator generators: vectors 102 to 104
// - two-wire collision: vector 181
// - converter compares and filter: vectors 185-187
// - equal level: lower table position wins
// - entries are 24-bit, table at 000004h
// - hardware sets flags, software clears, enables gate
`timescale 1ns/1ps
module ivm_controller (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [ivm_pkg::NUM_IRQ-1:0] irq_event,
    input wire logic vector_ack,
    output ivm_pkg::ivm_vector_type vector_out,
    output logic [23:0] program_counter,
    output logic boot_fetch
);
    ivm_pkg::ivm_state_type st;
    ivm_pkg::ivm_state_type next_st;

    logic [5:0] reg_idx;
    logic word_ok;
    logic in_flag;
    logic in_enable;
    logic in_prio;
    logic in_level;
    logic in_status;
    logic in_pc;
    logic mapped;
    logic apb_setup;
    logic wr_now;
    logic [31:0] rd_word;
    logic [ivm_pkg::NUM_IRQ-1:0] flag_clear;
    logic [ivm_pkg::NUM_IRQ-1:0] eligible;
    logic found;
    logic [7:0] pick_idx;
    logic [ivm_pkg::PRIO_W-1:0] pick_level;
    logic [7:0] pick_vector;

    assign reg_idx = paddr[7:2];
    assign word_ok = (paddr[1:0] == 2'h0);
    assign in_flag = word_ok && (paddr[11:8] == ivm_pkg::FLAG_BASE[11:8])
                     && (reg_idx < ivm_pkg::FLAG_REGS);
    assign in_enable = word_ok && (paddr[11:8] == ivm_pkg::ENABLE_BASE[11:8])
                       && (reg_idx < ivm_pkg::FLAG_REGS);
    assign in_prio = word_ok && (paddr[11:8] == ivm_pkg::PRIO_BASE[11:8])
                     && (reg_idx < ivm_pkg::PRIO_REGS);
    assign in_level = (paddr == ivm_pkg::CPU_LEVEL_ADDR);
    assign in_status = (paddr == ivm_pkg::STATUS_ADDR);
    assign in_pc = (paddr == ivm_pkg::PC_ADDR);
    assign mapped = in_flag || in_enable || in_prio || in_level || in_status || in_pc;

    assign apb_setup = psel && !penable;
    // writes land only at the edge that completes the access phase
    assign wr_now = psel && penable && st.pready && pwrite;

    // read word assembled during setup and held in prdata for the access
    always_comb begin
        rd_word = 32'h0;
        if (in_flag) begin
            rd_word[15:0] = st.flag[reg_idx*ivm_pkg::IRQ_PER_FLAG_REG +: 16];
        end
        if (in_enable) begin
            rd_word[15:0] = st.enable[reg_idx*ivm_pkg::IRQ_PER_FLAG_REG +: 16];
        end
        if (in_prio) begin
            for (int j = 0; j < ivm_pkg::IRQ_PER_PRIO_REG; j++) begin
                rd_word[j*ivm_pkg::PRIO_FIELD_STRIDE +: ivm_pkg::PRIO_W] =
                    st.prio[(reg_idx*ivm_pkg::IRQ_PER_PRIO_REG + j)*ivm_pkg::PRIO_W
                            +: ivm_pkg::PRIO_W];
            end
        end
        if (in_level) begin
            rd_word[2:0] = st.cpu_level;
        end
        if (in_status) begin
            rd_word[11:0] = {st.vec.request, st.vec.level, st.vec.number};
        end
        if (in_pc) begin
            rd_word[23:0] = st.program_counter;
        end
    end

    // a source may only compete with flag, enable, nonzero level above cpu
    always_comb begin
        eligible = '0;
        for (int i = 0; i < ivm_pkg::NUM_IRQ; i++) begin
            eligible[i] = st.flag[i] && st.enable[i] && ivm_pkg::IMPL_MASK[i]
                          && (st.prio[i*ivm_pkg::PRIO_W +: ivm_pkg::PRIO_W] != 3'h0)
                          && (st.prio[i*ivm_pkg::PRIO_W +: ivm_pkg::PRIO_W]
                              > st.cpu_level);
        end
    end

    ivm_pick #(
        .N(ivm_pkg::NUM_IRQ),
        .W(ivm_pkg::PRIO_W)
    ) u_pick (
        .active(eligible),
        .level(st.prio),
        .found(found),
        .index(pick_idx),
        .best_level(pick_level)
    );

    // reset owns no slot: vectors begin above the trap area
    assign pick_vector = pick_idx + ivm_pkg::VECTOR_OFFSET;

    assign flag_clear = (wr_now && in_flag) ?
        (ivm_pkg::NUM_IRQ'(pwdata[15:0]) << (reg_idx*ivm_pkg::IRQ_PER_FLAG_REG)) : '0;

    always_comb begin
        next_st = st;
        // a new event beats a clear written in the same cycle
        next_st.flag = (st.flag & ~flag_clear) | (irq_event & ivm_pkg::IMPL_MASK);
        if (wr_now && in_enable) begin
            next_st.enable[reg_idx*ivm_pkg::IRQ_PER_FLAG_REG +: 16] = pwdata[15:0]
                & ivm_pkg::IMPL_MASK[reg_idx*ivm_pkg::IRQ_PER_FLAG_REG +: 16];
        end
        if (wr_now && in_prio) begin
            for (int j = 0; j < ivm_pkg::IRQ_PER_PRIO_REG; j++) begin
                if (ivm_pkg::IMPL_MASK[reg_idx*ivm_pkg::IRQ_PER_PRIO_REG + j]) begin
                    next_st.prio[(reg_idx*ivm_pkg::IRQ_PER_PRIO_REG + j)*ivm_pkg::PRIO_W
                                 +: ivm_pkg::PRIO_W] =
                        pwdata[j*ivm_pkg::PRIO_FIELD_STRIDE +: ivm_pkg::PRIO_W];
                end
            end
        end
        if (wr_now && in_level) begin
            next_st.cpu_level = pwdata[2:0];
        end
        // vector fields read zero while nothing is pending
        next_st.vec.request = found;
        next_st.vec.number = found ? pick_vector : 8'h00;
        next_st.vec.level = found ? pick_level : 3'h0;
        next_st.vec.address = found ?
            (ivm_pkg::TABLE_BASE + {15'h0, pick_vector, 1'b0}) : 24'h000000;
        if (vector_ack && st.vec.request) begin
            next_st.program_counter = st.vec.address;
        end
        next_st.boot_fetch = 1'b0;
        // one wait-free access phase; error flagged for unmapped words
        next_st.pready = apb_setup;
        next_st.pslverr = apb_setup && !mapped;
        if (apb_setup) begin
            next_st.prdata = (mapped && !pwrite) ? rd_word : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= ivm_pkg::STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign pready = st.pready;
    assign prdata = st.prdata;
    assign pslverr = st.pslverr;
    assign vector_out = st.vec;
    assign program_counter = st.program_counter;
    assign boot_fetch = st.boot_fetch;

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic wr_flag0_clear;
    assign wr_flag0_clear = wr_now && in_flag && (reg_idx == 6'h00) && pwdata[0];

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_answer;
        pready ##1 !pready;
    endsequence

    // tie between request zero and the spi done source, which the bench drives
    sequence s_tie;
        st.flag[ivm_pkg::IRQ_EXT_REQUEST_ZERO] && st.enable[ivm_pkg::IRQ_EXT_REQUEST_ZERO]
        && st.flag[ivm_pkg::IRQ_SPI_DONE_REQUEST] && st.enable[ivm_pkg::IRQ_SPI_DONE_REQUEST]
        && (st.prio[2:0] == st.prio[ivm_pkg::IRQ_SPI_DONE_REQUEST*ivm_pkg::PRIO_W +: 3])
        && (st.prio[2:0] > st.cpu_level);
    endsequence

    property p_map(vec, irq);
        st.vec.request && (st.vec.number == vec) |-> $past(st.flag[irq] && st.enable[irq]);
    endproperty

    a_apb_answer: assert property (s_setup |=> s_answer)
        else $error("apb access not answered in one cycle");
    a_boot_pc: assert property (boot_fetch |-> program_counter == ivm_pkg::RESET_ADDR
                                && !vector_out.request)
        else $error("first fetch not at reset address");
    a_no_reset_slot: assert property (vector_out.request
                                      |-> vector_out.number >= ivm_pkg::VECTOR_OFFSET)
        else $error("vector inside reset and trap area");
    a_no_reserved: assert property (vector_out.request
        |-> ivm_pkg::IMPL_MASK[vector_out.number - ivm_pkg::VECTOR_OFFSET])
        else $error("reserved vector requested");
    a_table_addr: assert property (vector_out.request |-> vector_out.address
        == ivm_pkg::TABLE_BASE + {15'h0, vector_out.number, 1'b0})
        else $error("table address does not match vector");
    a_level_gate: assert property (vector_out.request |-> vector_out.level != 3'h0
                                   && vector_out.level > $past(st.cpu_level))
        else $error("request at or below cpu level");
    a_flag_sticky: assert property (irq_event[ivm_pkg::IRQ_EXT_REQUEST_ZERO]
                                    |=> st.flag[ivm_pkg::IRQ_EXT_REQUEST_ZERO])
        else $error("event did not set its flag");
    a_flag_sw_clear: assert property ($fell(st.flag[ivm_pkg::IRQ_EXT_REQUEST_ZERO])
                                      |-> $past(wr_flag0_clear))
        else $error("flag cleared without software write");
    a_natural_order: assert property (s_tie |=> vector_out.request
                                      && vector_out.number == 8'h08)
        else $error("higher table position won a tie");
    a_ext_zero_map: assert property (p_map(8'h08, ivm_pkg::IRQ_EXT_REQUEST_ZERO))
        else $error("vector 8 without its source");
    a_ext_zero_level: assert property (vector_out.request && vector_out.number == 8'h08
                                       |-> vector_out.level == $past(st.prio[2:0]))
        else $error("vector 8 level not from first field");
    a_rx_map: assert property (p_map(8'h13, ivm_pkg::IRQ_SERIAL_RX_REQUEST))
        else $error("vector 19 without its source");
    a_rx_level: assert property (vector_out.request && vector_out.number == 8'h13
        |-> vector_out.level == $past(st.prio[ivm_pkg::IRQ_SERIAL_RX_REQUEST*3 +: 3]))
        else $error("vector 19 level mismatch");
    a_conv_map: assert property (p_map(8'h15, ivm_pkg::IRQ_CONVERTER_DONE))
        else $error("vector 21 without its source");
    a_nvm_map: assert property (p_map(8'h17, ivm_pkg::IRQ_NONVOLATILE_WRITE_DONE))
        else $error("vector 23 without its source");
    a_spi_map: assert property (p_map(8'h12, ivm_pkg::IRQ_SPI_DONE_REQUEST))
        else $error("vector 18 without its source");
    a_cmp_one_map: assert property (p_map(8'h1a, ivm_pkg::IRQ_ANALOG_COMPARATOR_ONE))
        else $error("vector 26 without its source");
    a_cmp_two_map: assert property (p_map(8'h6f, ivm_pkg::IRQ_ANALOG_COMPARATOR_TWO))
        else $error("vector 111 without its source");
    a_match_map: assert property (p_map(8'h41, ivm_pkg::IRQ_MODULATOR_SPECIAL_MATCH))
        else $error("vector 65 without its source");
    a_serr_map: assert property (p_map(8'h49, ivm_pkg::IRQ_SERIAL_ERROR))
        else $error("vector 73 without its source");
    a_gen_one_map: assert property (p_map(8'h66, ivm_pkg::IRQ_MODULATOR_GENERATOR_ONE))
        else $error("vector 102 without its source");
    a_gen_two_map: assert property (p_map(8'h67, ivm_pkg::IRQ_MODULATOR_GENERATOR_TWO))
        else $error("vector 103 without its source");
    a_gen_three_map: assert property (p_map(8'h68,
                                      ivm_pkg::IRQ_MODULATOR_GENERATOR_THREE))
        else $error("vector 104 without its source");
    a_collide_map: assert property (p_map(8'hb5, ivm_pkg::IRQ_TWO_WIRE_COLLISION))
        else $error("vector 181 without its source");
    a_dcmp_zero_map: assert property (p_map(8'hb9,
                                      ivm_pkg::IRQ_CONVERTER_DIGITAL_COMPARE_ZERO))
        else $error("vector 185 without its source");
    a_dcmp_one_map: assert property (p_map(8'hba,
                                     ivm_pkg::IRQ_CONVERTER_DIGITAL_COMPARE_ONE))
        else $error("vector 186 without its source");
    a_filter_map: assert property (p_map(8'hbb,
                                   ivm_pkg::IRQ_CONVERTER_OVERSAMPLE_FILTER))
        else $error("vector 187 without its source");
endmodule // ivm_controller

// [verification/ivm_core_model.sv]
// behavioural cpu core that takes vectors promptly or after a wait
`timescale 1ns/1ps
module ivm_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] ack_mode,
    input wire ivm_pkg::ivm_vector_type vector_out,
    output logic vector_ack
);
    // software's default entry for unused slots; placement is arbitrary
    localparam logic [23:0] DEFAULT_HANDLER = 24'h000200;
    logic [2:0] wait_count;
    logic [23:0] handler;

    // mode 0 never takes, 1 takes at once, 2 lets the request stand three cycles first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_ack <= 1'b0;
            wait_count <= 3'h0;
            handler <= 24'h000000;
        end else if (ack_mode == 2'h0 || vector_out.request !== 1'b1) begin
            vector_ack <= 1'b0;
            wait_count <= 3'h0;
        end else if (ack_mode == 2'h1 || wait_count == 3'h3) begin
            vector_ack <= 1'b1;
            wait_count <= 3'h0;
            handler <= ivm_pkg::IMPL_MASK[vector_out.number - 8'h08] ?
                vector_out.address : DEFAULT_HANDLER;
        end else begin
            vector_ack <= 1'b0;
            wait_count <= wait_count + 3'h1;
        end
    end
endmodule // ivm_core_model

// [verification/tb.sv]
// self-checking bench for the interrupt vector mapping controller
`timescale 1ns/1ps
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [ivm_pkg::NUM_IRQ-1:0] irq_event = '0;
    logic vector_ack;
    ivm_pkg::ivm_vector_type vector_out;
    logic [23:0] program_counter;
    logic boot_fetch;
    logic [1:0] ack_mode = 2'h0;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int n_checks = 0;

    always #4 pclk = ~pclk;

    ivm_controller i_ivm_controller (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .irq_event(irq_event), .vector_ack(vector_ack),
        .vector_out(vector_out), .program_counter(program_counter), .boot_fetch(boot_fetch));
    ivm_core_model i_ivm_core_model (.pclk(pclk), .presetn(presetn), .ack_mode(ack_mode),
        .vector_out(vector_out), .vector_ack(vector_ack));

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [11:0] fa(input logic [11:0] base, input int p, input int per);
        return base + 12'(4 * (p / per));
    endfunction

    // entered just after a rising edge; answer taken at the edge that sees pready high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge pclk);
            n++;
        end
        if (n == 16) begin
            chk(32'h0, 32'h1, "no pready");
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic pulse(input logic [ivm_pkg::NUM_IRQ-1:0] m);
        irq_event <= m;
        @(posedge pclk);
        irq_event <= '0;
        @(posedge pclk);
    endtask

    task automatic vec_chk(input logic req, input logic [7:0] num, input logic [2:0] lvl);
        @(negedge pclk);
        chk({31'h0, vector_out.request}, {31'h0, req}, "request");
        chk({24'h0, vector_out.number}, {24'h0, num}, "vector number");
        chk({29'h0, vector_out.level}, {29'h0, lvl}, "level");
        @(posedge pclk);
    endtask

    task automatic pc_wait(input logic [23:0] exp);
        int n;
        n = 0;
        @(negedge pclk);
        while (program_counter !== exp && n < 16) begin
            @(negedge pclk);
            n++;
        end
        chk({8'h0, program_counter}, {8'h0, exp}, "program counter");
        if (n == 16) close_out();
        @(posedge pclk);
    endtask

    task automatic test_reset();
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        @(negedge pclk);
        chk({31'h0, boot_fetch}, 32'h1, "boot fetch in reset");
        chk({8'h0, program_counter}, 32'h0, "pc in reset");
        chk({31'h0, vector_out.request}, 32'h0, "vector in reset");
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk({31'h0, boot_fetch}, 32'h0, "boot fetch after release");
        @(posedge pclk);
        for (int k = 0; k < 12; k++) begin
            apb(1'b0, fa(ivm_pkg::FLAG_BASE, 16 * k, 16), 32'h0);
            chk(rd, 32'h0, "flags after reset");
        end
        $display("test reset done");
    endtask

    task automatic test_map();
        int vecs[16] = '{8, 18, 19, 21, 23, 26, 65, 73, 102, 103, 104, 111, 181, 185, 186, 187};
        int p;
        foreach (vecs[i]) begin
            p = vecs[i] - 8;
            apb(1'b1, fa(ivm_pkg::ENABLE_BASE, p, 16), 32'h1 << (p % 16));
            apb(1'b1, fa(ivm_pkg::PRIO_BASE, p, 4), 32'h3 << (4 * (p % 4)));
            pulse(192'h1 << p);
            vec_chk(1'b1, 8'(vecs[i]), 3'h3);
            chk({8'h0, vector_out.address}, 32'h4 + 32'h2 * vecs[i], "entry");
            apb(1'b0, fa(ivm_pkg::FLAG_BASE, p, 16), 32'h0);
            chk(rd, 32'h1 << (p % 16), "flag set");
            apb(1'b1, fa(ivm_pkg::FLAG_BASE, p, 16), 32'hffff);
            apb(1'b1, fa(ivm_pkg::ENABLE_BASE, p, 16), 32'h0);
            apb(1'b1, fa(ivm_pkg::PRIO_BASE, p, 4), 32'h0);
            apb(1'b0, ivm_pkg::STATUS_ADDR, 32'h0);
            chk(rd, 32'h0, "idle after clear");
        end
        $display("test map done");
    endtask

    task automatic test_prio();
        apb(1'b1, ivm_pkg::ENABLE_BASE, 32'h0401);
        apb(1'b1, ivm_pkg::PRIO_BASE, 32'h4);
        apb(1'b1, ivm_pkg::PRIO_BASE + 12'h8, 32'h400);
        pulse(192'h401);
        vec_chk(1'b1, 8'h08, 3'h4);
        apb(1'b1, ivm_pkg::PRIO_BASE + 12'h8, 32'h500);
        vec_chk(1'b1, 8'h12, 3'h5);
        apb(1'b1, ivm_pkg::CPU_LEVEL_ADDR, 32'h5);
        vec_chk(1'b0, 8'h00, 3'h0);
        apb(1'b1, ivm_pkg::CPU_LEVEL_ADDR, 32'h3);
        vec_chk(1'b1, 8'h12, 3'h5);
        apb(1'b1, ivm_pkg::PRIO_BASE + 12'h8, 32'h0);
        vec_chk(1'b1, 8'h08, 3'h4);
        apb(1'b1, ivm_pkg::ENABLE_BASE, 32'h0);
        vec_chk(1'b0, 8'h00, 3'h0);
        apb(1'b0, ivm_pkg::FLAG_BASE, 32'h0);
        chk(rd, 32'h0401, "flags survive disable");
        // reserved position 4 is written enable and level, keeps neither, and must stay silent
        apb(1'b1, ivm_pkg::ENABLE_BASE, 32'h10);
        apb(1'b1, ivm_pkg::PRIO_BASE + 12'h4, 32'h7);
        pulse(192'h10);
        vec_chk(1'b0, 8'h00, 3'h0);
        apb(1'b0, ivm_pkg::ENABLE_BASE, 32'h0);
        chk(rd, 32'h0, "reserved enable");
        apb(1'b1, ivm_pkg::FLAG_BASE, 32'hffff);
        apb(1'b1, ivm_pkg::CPU_LEVEL_ADDR, 32'h0);
        $display("test priority done");
    endtask

    task automatic test_ack();
        apb(1'b1, ivm_pkg::ENABLE_BASE, 32'h2000);
        apb(1'b1, ivm_pkg::PRIO_BASE + 12'hc, 32'h20);
        ack_mode <= 2'h1;
        pulse(192'h1 << 13);
        pc_wait(24'h00002e);
        chk({8'h0, i_ivm_core_model.handler}, 32'h2e, "core handler entry");
        ack_mode <= 2'h0;
        apb(1'b1, ivm_pkg::FLAG_BASE, 32'hffff);
        apb(1'b1, ivm_pkg::ENABLE_BASE + 12'hc, 32'h200);
        apb(1'b1, ivm_pkg::PRIO_BASE + 12'h38, 32'h20);
        ack_mode <= 2'h2;
        pulse(192'h1 << 57);
        pc_wait(24'h000086);
        ack_mode <= 2'h0;
        apb(1'b0, ivm_pkg::PC_ADDR, 32'h0);
        chk(rd, 32'h86, "pc register");
        apb(1'b0, 12'h400, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        apb(1'b0, ivm_pkg::FLAG_BASE + 12'h002, 32'h0);
        chk({31'h0, err}, 32'h1, "misaligned error");
        $display("test ack done");
    endtask

    initial begin
        test_reset();
        test_map();
        test_prio();
        test_ack();
        test_reset();
        close_out();
    end
endmodule // tb
